// ===== logic/pns_dwell.sv
`timescale 1ns/1ps
module pns_dwell
   import pns_pkg::*;
#(
   parameter logic [15:0] PERIOD_US = IPO_PERIOD_US
) (
   input  wire logic        clk,      // System clock
   input  wire logic        rst,      // Async reset
   input  wire logic        start,    // Start a dwell
   input  wire logic        ipo_tick, // Interpolation cycle tick
   input  wire logic [15:0] dwell_us, // Dwell in microseconds
   output logic             done      // One-cycle end of dwell
);
   logic [16:0] elapsed;
   logic        run;

   // Whole ticks are counted until elapsed time covers the dwell,
   // which rounds any remainder up to one more cycle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         run     <= 1'b0;
         elapsed <= 17'h00000;
         done    <= 1'b0;
      end else begin
         done <= 1'b0;
         if (start) begin
            run     <= 1'b1;
            elapsed <= 17'h00000;
         end else if (run && ({1'b0, dwell_us} <= elapsed)) begin
            run  <= 1'b0;
            done <= 1'b1;
         end else if (run && ipo_tick) begin
            elapsed <= elapsed + {1'b0, PERIOD_US};
         end
      end
   end
endmodule // pns_dwell

// ===== logic/pns_sequencer.sv
// Implementation choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
module pns_sequencer
   import pns_pkg::*;
#(
   parameter logic [15:0] PERIOD_US = IPO_PERIOD_US
) (
   input  wire logic             CLK_SYS,      // 25 MHz clock
   input  wire logic             SYS_RST,      // Async reset, high
   input  wire logic             PSEL,         // APB select
   input  wire logic             PENABLE,      // APB enable
   input  wire logic             PWRITE,       // APB direction
   input  wire logic [7:0]       PADDR,        // APB byte address
   input  wire logic [31:0]      PWDATA,       // APB write data
   output logic      [31:0]      PRDATA,       // APB read data
   output logic                  PREADY,       // APB ready
   output logic                  PSLVERR,      // APB error
   input  wire pns_pkg::pns_blk_s BLK,         // Block events
   input  wire logic             IPO_TICK,     // Interpolation tick
   input  wire logic             POS_TICK,     // Position cycle tick
   input  wire logic             PLC_SUPPRESS, // Stroke suppression pin
   input  wire logic [1:0]       STROKE_ACT,   // Stroke-active pins
   output logic      [1:0]       STROKE_OUT,   // Stroke initiation pins
   output logic                  STROKE_INIT,  // Initiation active
   output logic                  MOTION_HOLD   // Axes wait for start-point stroke
);
   import pns_pkg::*;

   pns_mode_e   mode;
   pns_state_e  state;
   logic        delay_on;
   logic        if_second;
   logic        cur_second;
   logic        first_blk;
   logic        end_armed;
   logic        req_start;
   logic        req_end;
   logic        cur_start;
   logic [15:0] dwell_us;
   logic [15:0] stroke_cnt;
   logic [1:0]  act_sync;
   logic        supp_sync;
   logic        dwell_done;

   logic        wr_en;
   logic        rd_en;
   logic        cmd_wr;
   logic        mapped;
   logic [2:0]  mode_cmd;
   logic [1:0]  dly_cmd;
   logic [1:0]  if_cmd;
   logic        prog_end;
   logic        is_off;
   logic        is_nib;
   logic        is_punch;
   logic        eval_tick;
   logic        act_now;
   logic        take;
   logic        take_start;
   logic        set_start;
   logic        set_end;
   logic        dwell_go;
   pns_status_s status;

   pns_sync #(
      .W (3)
   ) u_sync (
      .clk (CLK_SYS),
      .rst (SYS_RST),
      .d   ({PLC_SUPPRESS, STROKE_ACT}),
      .q   ({supp_sync, act_sync})
   );

   pns_dwell #(
      .PERIOD_US (PERIOD_US)
   ) u_dwell (
      .clk      (CLK_SYS),
      .rst      (SYS_RST),
      .start    (dwell_go),
      .ipo_tick (IPO_TICK),
      .dwell_us (dwell_us),
      .done     (dwell_done)
   );

   // Bus decode; the slave always answers in the access cycle
   assign wr_en    = PSEL && PENABLE && PWRITE;
   assign rd_en    = PSEL && PENABLE && !PWRITE;
   assign mapped   = (PADDR == ADDR_CMD) || (PADDR == ADDR_STATUS) ||
                     (PADDR == ADDR_DWELL) || (PADDR == ADDR_COUNT);
   assign cmd_wr   = wr_en && (PADDR == ADDR_CMD);
   assign PREADY   = 1'b1;
   assign PSLVERR  = PSEL && PENABLE && !mapped;

   assign mode_cmd = cmd_wr ? PWDATA[CMD_MODE_LSB +: 3] : MC_NONE;
   assign dly_cmd  = cmd_wr ? PWDATA[CMD_DLY_LSB +: 2] : 2'h0;
   assign if_cmd   = cmd_wr ? PWDATA[CMD_IF_LSB +: 2] : 2'h0;
   assign prog_end = cmd_wr && PWDATA[CMD_PEND_BIT];

   assign is_off   = (mode == MD_OFF);
   assign is_nib   = (mode == MD_NIB) || (mode == MD_NIB_POS);
   assign is_punch = (mode == MD_PUN) || (mode == MD_PUN_POS);

   // Position-cycle variants judge triggers on the faster tick
   assign eval_tick = ((mode == MD_NIB_POS) || (mode == MD_PUN_POS)) ?
                      POS_TICK : IPO_TICK;

   // The monitored input follows the interface of the running stroke
   assign act_now  = cur_second ? act_sync[1] : act_sync[0];

   assign take       = (state == ST_IDLE) && !is_off &&
                       (req_start || req_end);
   assign take_start = take && req_start;
   assign dwell_go   = take && !req_start && delay_on && !supp_sync;

   // Stroke requests raised by block events
   always_comb begin
      set_start = 1'b0;
      set_end   = 1'b0;
      if (!is_off) begin
         if (BLK.start) begin
            if (!BLK.axis) begin
               set_end = first_blk;
            end else if (is_nib && first_blk) begin
               set_start = 1'b1;
            end else if (is_punch && first_blk) begin
               set_start = 1'b0;
            end
         end
         if (end_armed && BLK.motion_end) begin
            set_end = 1'b1;
         end
         if (end_armed && is_punch && BLK.seg_end && !BLK.motion_end) begin
            set_end = 1'b1;
         end
      end
   end

   assign MOTION_HOLD = req_start || (cur_start && (state != ST_IDLE));

   // Punch mode group, one-hot so only one member is ever active
   always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
      if (SYS_RST) begin
         mode <= MD_OFF;
      end else if (prog_end) begin
         mode <= MD_OFF;
      end else begin
         unique case (mode_cmd)
            MC_OFF:     mode <= MD_OFF;
            MC_NIB:     mode <= MD_NIB;
            MC_NIB_POS: mode <= MD_NIB_POS;
            MC_PUN:     mode <= MD_PUN;
            MC_PUN_POS: mode <= MD_PUN_POS;
            default:    mode <= mode;
         endcase
      end
   end

   // First block after a mode entry gets the start-point stroke in the nibbling modes only
   always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
      if (SYS_RST) begin
         first_blk <= 1'b0;
      end else if ((mode_cmd == MC_NIB && !is_nib) ||
                   (mode_cmd == MC_NIB_POS && !is_nib) ||
                   (mode_cmd == MC_PUN && !is_punch) ||
                   (mode_cmd == MC_PUN_POS && !is_punch)) begin
         first_blk <= 1'b1;
      end else if (mode_cmd == MC_OFF || prog_end) begin
         first_blk <= 1'b0;
      end else if (BLK.start && !is_off) begin
         first_blk <= 1'b0;
      end
   end

   // Block end stroke is due only when a punch axis is named
   always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
      if (SYS_RST) begin
         end_armed <= 1'b0;
      end else if (is_off || mode_cmd == MC_OFF) begin
         end_armed <= 1'b0;
      end else if (BLK.start) begin
         end_armed <= BLK.axis;
      end else if (BLK.motion_end) begin
         end_armed <= 1'b0;
      end
   end

   // Delay pair and interface pair, both modal
   always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
      if (SYS_RST) begin
         delay_on <= 1'b0;
      end else if (dly_cmd == PAIR_CMD_ON) begin
         delay_on <= 1'b1;
      end else if (dly_cmd == PAIR_CMD_OFF) begin
         delay_on <= 1'b0;
      end
   end

   always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
      if (SYS_RST) begin
         if_second <= 1'b0;
      end else if (if_cmd == PAIR_CMD_ON) begin
         if_second <= 1'b0;
      end else if (if_cmd == PAIR_CMD_OFF) begin
         if_second <= 1'b1;
      end
   end

   // Pending requests; a new event wins over the clearing take
   always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
      if (SYS_RST) begin
         req_start <= 1'b0;
         req_end   <= 1'b0;
      end else if (is_off || mode_cmd == MC_OFF) begin
         req_start <= 1'b0;
         req_end   <= 1'b0;
      end else begin
         req_start <= (req_start && !take_start) || set_start;
         req_end   <= (req_end && !(take && !req_start)) || set_end;
      end
   end

   // Stroke sequencer
   always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
      if (SYS_RST) begin
         state       <= ST_IDLE;
         cur_start   <= 1'b0;
         cur_second  <= 1'b0;
         STROKE_OUT  <= 2'b00;
         STROKE_INIT <= 1'b0;
      end else if (is_off) begin
         state       <= ST_IDLE;
         cur_start   <= 1'b0;
         STROKE_OUT  <= 2'b00;
         STROKE_INIT <= 1'b0;
      end else begin
         unique case (state)
            ST_IDLE: begin
               if (take && supp_sync) begin
                  state <= ST_IDLE;
               end else if (take) begin
                  cur_start  <= req_start;
                  cur_second <= if_second;
                  state      <= dwell_go ? ST_DWELL : ST_ARM;
               end
            end
            ST_DWELL: begin
               if (dwell_done) begin
                  state <= ST_ARM;
               end
            end
            ST_ARM: begin
               if (eval_tick && !act_now) begin
                  state       <= ST_FIRE;
                  STROKE_OUT  <= cur_second ? 2'b10 : 2'b01;
                  STROKE_INIT <= 1'b1;
               end
            end
            ST_FIRE: begin
               if (act_now) begin
                  state      <= ST_BUSY;
                  STROKE_OUT <= 2'b00;
               end
            end
            ST_BUSY: begin
               if (!act_now) begin
                  state       <= ST_IDLE;
                  cur_start   <= 1'b0;
                  STROKE_INIT <= 1'b0;
               end
            end
         endcase
      end
   end

   // Dwell setting register
   always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
      if (SYS_RST) begin
         dwell_us <= DWELL_RST;
      end else if (wr_en && PADDR == ADDR_DWELL) begin
         dwell_us <= PWDATA[15:0];
      end
   end

   // Count of strokes issued, cleared by writing the count word unless a stroke fires in that cycle
   always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
      if (SYS_RST) begin
         stroke_cnt <= COUNT_RST;
      end else if (state == ST_ARM && eval_tick && !act_now && !is_off) begin
         stroke_cnt <= stroke_cnt + 16'h0001;
      end else if (wr_en && PADDR == ADDR_COUNT) begin
         stroke_cnt <= COUNT_RST;
      end
   end

   always_comb begin
      status           = '0;
      status.mode      = mode;
      status.delay_on  = delay_on;
      status.if_second = if_second;
      status.state     = state;
      status.hold      = MOTION_HOLD;
      status.act_in    = is_off ? 1'b0 : act_now;
   end

   // Read data is registered in the setup cycle, valid in access
   always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
      if (SYS_RST) begin
         PRDATA <= 32'h00000000;
      end else if (PSEL && !PENABLE && !PWRITE) begin
         unique case (PADDR)
            ADDR_STATUS: PRDATA <= status;
            ADDR_DWELL:  PRDATA <= {16'h0000, dwell_us};
            ADDR_COUNT:  PRDATA <= {16'h0000, stroke_cnt};
            default:     PRDATA <= 32'h00000000;
         endcase
      end else if (!rd_en) begin
         PRDATA <= 32'h00000000;
      end
   end

endmodule // pns_sequencer

// ===== logic/pns_sync.sv
`timescale 1ns/1ps
module pns_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,   // System clock
   input  wire logic         rst,   // Async reset
   input  wire logic [W-1:0] d,     // Asynchronous input
   output logic      [W-1:0] q      // Synchronised output
);
   logic [W-1:0] meta;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta <= '0;
         q    <= '0;
      end else begin
         meta <= d;
         q    <= meta;
      end
   end
endmodule // pns_sync

// ===== shared/pns_pkg.sv
package pns_pkg;

   localparam logic [7:0]  ADDR_CMD      = 8'h00;
   localparam logic [7:0]  ADDR_STATUS   = 8'h04;
   localparam logic [7:0]  ADDR_DWELL    = 8'h08;
   localparam logic [7:0]  ADDR_COUNT    = 8'h0c;

   localparam int          CMD_MODE_LSB  = 0;
   localparam int          CMD_DLY_LSB   = 3;
   localparam int          CMD_IF_LSB    = 5;
   localparam int          CMD_PEND_BIT  = 7;

   localparam logic [2:0]  MC_NONE       = 3'h0;
   localparam logic [2:0]  MC_OFF        = 3'h1;
   localparam logic [2:0]  MC_NIB        = 3'h2;
   localparam logic [2:0]  MC_NIB_POS    = 3'h3;
   localparam logic [2:0]  MC_PUN        = 3'h4;
   localparam logic [2:0]  MC_PUN_POS    = 3'h5;

   localparam logic [1:0]  PAIR_CMD_ON   = 2'h1;
   localparam logic [1:0]  PAIR_CMD_OFF  = 2'h2;

   localparam logic [15:0] DWELL_RST     = 16'h0000;
   localparam logic [15:0] IPO_PERIOD_US = 16'h1388;
   localparam logic [15:0] COUNT_RST     = 16'h0000;

   typedef enum logic [4:0] {
      MD_OFF     = 5'b00001,
      MD_NIB     = 5'b00010,
      MD_NIB_POS = 5'b00100,
      MD_PUN     = 5'b01000,
      MD_PUN_POS = 5'b10000
   } pns_mode_e;

   typedef enum logic [4:0] {
      ST_IDLE  = 5'b00001,
      ST_DWELL = 5'b00010,
      ST_ARM   = 5'b00100,
      ST_FIRE  = 5'b01000,
      ST_BUSY  = 5'b10000
   } pns_state_e;

   typedef struct packed {
      logic start;
      logic axis;
      logic seg_end;
      logic motion_end;
   } pns_blk_s;

   typedef struct packed {
      logic [17:0] zero;
      logic        act_in;
      logic        hold;
      pns_state_e  state;
      logic        if_second;
      logic        delay_on;
      pns_mode_e   mode;
   } pns_status_s;

endpackage

// ===== testbench/pns_punch_unit.sv
`timescale 1ns/1ps
module pns_punch_unit (
   input  wire logic       clk,    // System clock
   input  wire logic       rst,    // Power-up reset
   input  wire logic       strike, // Stroke command
   input  wire logic [3:0] lag,    // Reaction cycles
   output logic            act     // Stroke active
);
   logic [1:0] ph;
   logic [3:0] cnt;
   // A started stroke always completes, even if the command is withdrawn
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ph <= 2'h0;
         cnt <= 4'h0;
         act <= 1'b0;
      end else begin
         case (ph)
            2'h0: if (strike) begin
               ph <= 2'h1;
               cnt <= lag;
            end
            2'h1: if (cnt == 4'h0) begin
               act <= 1'b1;
               ph <= 2'h2;
               cnt <= lag;
            end else begin
               cnt <= cnt - 4'h1;
            end
            default: if (!strike && cnt == 4'h0) begin
               act <= 1'b0;
               ph <= 2'h0;
            end else if (!strike) begin
               cnt <= cnt - 4'h1;
            end
         endcase
      end
   end
endmodule // pns_punch_unit

// ===== testbench/pns_sequencer_properties.sv
`timescale 1ns/1ps
module pns_props (
   input wire logic        CLK_SYS,     // Clock
   input wire logic        SYS_RST,     // Reset
   input wire logic        PSEL,        // APB select
   input wire logic        PENABLE,     // APB enable
   input wire logic        PWRITE,      // APB direction
   input wire logic [7:0]  PADDR,       // APB address
   input wire logic [31:0] PWDATA,      // APB write data
   input wire logic [1:0]  STROKE_ACT,  // Stroke-active pins
   input wire logic [1:0]  STROKE_OUT,  // Stroke outputs
   input wire logic        STROKE_INIT, // Initiation active
   input wire logic        MOTION_HOLD  // Axis hold
);
   import pns_pkg::*;
   logic cmd_wr;
   logic off_q;
   logic sel2;
   assign cmd_wr = PSEL && PENABLE && PWRITE && PADDR == ADDR_CMD;
   // Mode off as seen from the command writes
   always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
      if (SYS_RST) begin
         off_q <= 1'b1;
      end else if (cmd_wr && (PWDATA[7] || PWDATA[2:0] == MC_OFF)) begin
         off_q <= 1'b1;
      end else if (cmd_wr && PWDATA[2:0] >= MC_NIB &&
                   PWDATA[2:0] <= MC_PUN_POS) begin
         off_q <= 1'b0;
      end
   end
   always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
      if (SYS_RST) begin
         sel2 <= 1'b0;
      end else if (cmd_wr && PWDATA[6:5] != 2'h0) begin
         sel2 <= (PWDATA[6:5] == 2'h2);
      end
   end
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (SYS_RST);
   sequence s_off_wr;
      cmd_wr && (PWDATA[7] || PWDATA[2:0] == MC_OFF);
   endsequence
   sequence s_rise;
      $rose(|STROKE_OUT);
   endsequence
   a_off_drop: assert property (
      s_off_wr |-> ##2 (STROKE_OUT == 2'b00 && !STROKE_INIT))
      else $error("stroke still up after off");
   a_off_quiet: assert property (
      off_q && $past(off_q) |-> STROKE_OUT == 2'b00 && !MOTION_HOLD)
      else $error("stroke activity while off");
   a_pair_select: assert property (
      s_rise |-> STROKE_OUT == (sel2 ? 2'b10 : 2'b01))
      else $error("stroke on wrong pair");
   a_one_pair: assert property (
      STROKE_OUT != 2'b11)
      else $error("both pairs stroked");
   a_init_cover: assert property (
      STROKE_OUT != 2'b00 |-> STROKE_INIT)
      else $error("output without initiation flag");
   a_reset_clears: assert property (
      $fell(SYS_RST) |-> STROKE_OUT == 2'b00 && !STROKE_INIT)
      else $error("stroke survives reset");
   a_fall_on_ack: assert property (
      STROKE_OUT == 2'b00 && $past(STROKE_OUT) != 2'b00 && !off_q
      |-> ($past(STROKE_ACT, 3) & $past(STROKE_OUT)) != 2'b00)
      else $error("output dropped without ack");
   a_no_early: assert property (
      s_rise |-> ($past(STROKE_ACT, 3) & STROKE_OUT) == 2'b00)
      else $error("stroke while unit active");
endmodule // pns_props

bind pns_sequencer pns_props u_props (
   .CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST), .PSEL(PSEL), .PENABLE(PENABLE),
   .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
   .STROKE_ACT(STROKE_ACT), .STROKE_OUT(STROKE_OUT),
   .STROKE_INIT(STROKE_INIT), .MOTION_HOLD(MOTION_HOLD));

// ===== testbench/tb.sv
`timescale 1ns/1ps
module tb;
   import pns_pkg::*;
   localparam logic [15:0] PER = 16'h0064;
   logic CLK_SYS = 1'b0;
   logic SYS_RST = 1'b1;
   logic PSEL = 1'b0;
   logic PENABLE = 1'b0;
   logic PWRITE = 1'b0;
   logic [7:0] PADDR = 8'h00;
   logic [31:0] PWDATA = 32'h0;
   logic [31:0] PRDATA;
   logic PREADY, PSLVERR, STROKE_INIT, MOTION_HOLD;
   pns_blk_s BLK = 4'h0;
   logic IPO_TICK = 1'b0;
   logic POS_TICK = 1'b0;
   logic PLC_SUPPRESS = 1'b0;
   wire logic [1:0] STROKE_ACT;
   logic [1:0] STROKE_OUT;
   logic [1:0] out_q = 2'b00;
   logic [1:0] rise_tk = 2'b00;
   logic [4:0] phase = 5'd0;
   logic ipo_q = 1'b0;
   logic pos_q = 1'b0;
   logic [31:0] r;
   logic e;
   int miscompares = 0, n_tests = 0, cycles = 0;
   int nst0 = 0, nst1 = 0, ticks = 0, rise_ticks = 0;

   always #20 CLK_SYS = ~CLK_SYS;

   pns_sequencer #(.PERIOD_US(PER)) dut (
      .CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST), .PSEL(PSEL), .PENABLE(PENABLE),
      .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
      .PREADY(PREADY), .PSLVERR(PSLVERR), .BLK(BLK), .IPO_TICK(IPO_TICK),
      .POS_TICK(POS_TICK), .PLC_SUPPRESS(PLC_SUPPRESS),
      .STROKE_ACT(STROKE_ACT), .STROKE_OUT(STROKE_OUT),
      .STROKE_INIT(STROKE_INIT), .MOTION_HOLD(MOTION_HOLD));
   pns_punch_unit u_unit0 (.clk(CLK_SYS), .rst(SYS_RST),
      .strike(STROKE_OUT[0]), .lag(4'h2), .act(STROKE_ACT[0]));
   pns_punch_unit u_unit1 (.clk(CLK_SYS), .rst(SYS_RST),
      .strike(STROKE_OUT[1]), .lag(4'h6), .act(STROKE_ACT[1]));

   // Tick phases never coincide, so a stroke shows which tick fired it
   always @(posedge CLK_SYS) begin
      phase <= (phase == 5'd19) ? 5'd0 : phase + 5'd1;
      IPO_TICK <= (phase == 5'd19);
      POS_TICK <= (phase % 5 == 0);
      ipo_q <= IPO_TICK;
      pos_q <= POS_TICK;
      out_q <= STROKE_OUT;
      ticks <= BLK.motion_end ? 0 : ticks + IPO_TICK;
      if (STROKE_OUT[0] && !out_q[0]) nst0 <= nst0 + 1;
      if (STROKE_OUT[1] && !out_q[1]) nst1 <= nst1 + 1;
      if (STROKE_OUT != 2'b00 && out_q == 2'b00) begin
         rise_tk <= {pos_q, ipo_q};
         rise_ticks <= ticks;
      end
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         miscompares++;
         end_sim();
      end
   end

   task automatic chk(input string what, input logic [31:0] exp, got);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      @(posedge CLK_SYS);
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CLK_SYS);
      PENABLE <= 1'b1;
      n = 0;
      do begin
         @(posedge CLK_SYS);
         n++;
      end while (PREADY !== 1'b1 && n < 50);
      if (n >= 50) miscompares++;
      r = PRDATA;
      e = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
   endtask

   task automatic rd_chk(input string what, input logic [7:0] a,
                         input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(what, exp, r);
   endtask

   task automatic pulse(input logic [3:0] v);
      do @(posedge CLK_SYS); while (phase != 5'd4);
      BLK <= v;
      @(posedge CLK_SYS);
      BLK <= 4'h0;
   endtask

   task automatic quiet();
      int q;
      q = 0;
      while (q < 100) begin
         @(posedge CLK_SYS);
         if (STROKE_OUT === 2'b00 && STROKE_INIT === 1'b0
             && MOTION_HOLD === 1'b0) q++;
         else q = 0;
      end
   endtask

   task automatic wait_init();
      int n;
      n = 0;
      while (STROKE_INIT !== 1'b1 && n < 500) begin
         @(posedge CLK_SYS);
         n++;
      end
      chk("init wait", 32'h1, {31'h0, STROKE_INIT});
   endtask

   // One block: start, segment ends, motion end; counts strokes per pair
   task automatic run_blk(input logic axis, input int nseg,
                          input logic [7:0] es, e1, e0);
      int b0, b1;
      b0 = nst0;
      b1 = nst1;
      pulse({1'b1, axis, 2'b00});
      quiet();
      if (axis) chk("start strokes", {24'h0, es}, 32'(nst0 + nst1 - b0 - b1));
      repeat (nseg) begin
         pulse(4'h2);
         quiet();
      end
      pulse(4'h1);
      quiet();
      chk("strokes", {16'h0, e1, e0},
          {16'h0, 8'(nst1 - b1), 8'(nst0 - b0)});
   endtask

   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   initial begin
      repeat (20) @(posedge CLK_SYS);
      SYS_RST <= 1'b0;
      rd_chk("status", ADDR_STATUS, 32'h81);
      rd_chk("dwell", ADDR_DWELL, 32'h0);
      rd_chk("count", ADDR_COUNT, 32'h0);
      apb(1'b0, 8'h10, 32'h0);
      chk("slverr", 32'h1, {31'h0, e});
      run_blk(1'b1, 0, 8'h0, 8'h0, 8'h0);
      for (int m = 2; m <= 5; m++) begin
         apb(1'b1, ADDR_CMD, {29'h0, MC_OFF});
         apb(1'b1, ADDR_CMD, 32'(m));
         rd_chk("mode", ADDR_STATUS, 32'h80 | 32'h1 << m - 1);
         run_blk(1'b0, 0, 8'h0, 8'h0, 8'h1);
         chk("tick", m % 2 ? 32'h2 : 32'h1, {30'h0, rise_tk});
      end
      apb(1'b1, ADDR_CMD, {29'h0, MC_OFF});
      apb(1'b1, ADDR_CMD, {29'h0, MC_NIB});
      apb(1'b1, ADDR_COUNT, 32'h0);
      run_blk(1'b1, 0, 8'h1, 8'h0, 8'h2);
      rd_chk("count", ADDR_COUNT, 32'h2);
      run_blk(1'b1, 0, 8'h0, 8'h0, 8'h1);
      run_blk(1'b0, 0, 8'h0, 8'h0, 8'h0);
      apb(1'b1, ADDR_CMD, {29'h0, MC_PUN});
      rd_chk("mode", ADDR_STATUS, 32'h88);
      run_blk(1'b1, 2, 8'h0, 8'h0, 8'h3);
      apb(1'b1, ADDR_CMD, 32'h40);
      rd_chk("pair", ADDR_STATUS, 32'hc8);
      run_blk(1'b1, 0, 8'h0, 8'h1, 8'h0);
      run_blk(1'b1, 1, 8'h0, 8'h2, 8'h0);
      apb(1'b1, ADDR_CMD, 32'h20);
      run_blk(1'b1, 0, 8'h0, 8'h0, 8'h1);
      apb(1'b1, ADDR_CMD, 32'h08);
      rd_chk("delay", ADDR_STATUS, 32'ha8);
      for (int i = 0; i < 3; i++) begin
         apb(1'b1, ADDR_DWELL, (i == 0) ? 32'h0 : 32'(PER) + 32'(i - 1));
         run_blk(1'b1, 0, 8'h0, 8'h0, 8'h1);
         chk("dwell ticks", 32'(i + 1), 32'(rise_ticks));
      end
      apb(1'b1, ADDR_CMD, 32'h10);
      rd_chk("delay", ADDR_STATUS, 32'h88);
      run_blk(1'b1, 0, 8'h0, 8'h0, 8'h1);
      chk("dwell ticks", 32'h1, 32'(rise_ticks));
      apb(1'b1, ADDR_CMD, 32'h40);
      pulse(4'hc);
      pulse(4'h1);
      wait_init();
      apb(1'b1, ADDR_CMD, {29'h0, MC_OFF});
      quiet();
      rd_chk("off", ADDR_STATUS, 32'hc1);
      apb(1'b1, ADDR_CMD, {29'h0, MC_NIB});
      pulse(4'hc);
      wait_init();
      SYS_RST <= 1'b1;
      @(posedge CLK_SYS);
      chk("init", 32'h0, {29'h0, STROKE_OUT, STROKE_INIT});
      repeat (2) @(posedge CLK_SYS);
      SYS_RST <= 1'b0;
      rd_chk("status", ADDR_STATUS, 32'h81);
      end_sim();
   end
endmodule // tb
